// file: design/acfg_pkg.sv
// Purpose: shared constants for the serial converter configuration link
// Assumes: 250 MHz system clock on both ends
// Notes: Function
// Function
// - 12-bit write-only config captured on sclk falls
// - config shifted in while result shifts out
// - host gives sixteen sclk cycles per frame
// - only first twelve falling edges load config
// - msb first; bit 11 commit, bit 0 coding
// - commit bit 0 leaves register unchanged
// - sequencer bits 10 and 3 select mode
// - channel field applies after current conversion
// - channel field is plain unsigned binary
// - channel number precedes twelve result bits
// - mux switches on fourteenth falling edge
// - power mode 11 keeps device powered
// - power mode 10 shuts down until changed
// - power mode 01 sleeps after updating conversion
// - host waits one microsecond wake time
// - host never sends power mode 00
// - span bit 0 twice reference, 1 reference
// - coding bit 0 two's complement, 1 binary
// - mode 0,1 loads next frame into table
// - mode 1,1 cycles channels zero to field
// - mode 0,0 uses last committed channel field
package acfg_pkg;
   localparam int CFG_W = 12;
   localparam int FRAME_BITS = 16;
   localparam int RES_W = 12;
   localparam int CH_W = 3;
   localparam int BIT_WRITE = 11;
   localparam int BIT_SEQ = 10;
   localparam int BIT_ADDR_HI = 8;
   localparam int BIT_ADDR_LO = 6;
   localparam int BIT_PM_HI = 5;
   localparam int BIT_PM_LO = 4;
   localparam int BIT_SHADOW = 3;
   localparam int BIT_RANGE = 1;
   localparam int BIT_CODING = 0;
   localparam logic [4:0] CNT_CFG_LAST = 5'h0b;
   localparam logic [4:0] CNT_MUX = 5'h0d;
   localparam logic [4:0] CNT_LAST = 5'h0f;
   localparam logic [4:0] CNT_FULL = 5'h10;
   localparam logic [1:0] PM_NORMAL = 2'h3;
   localparam logic [1:0] PM_SHUTDOWN = 2'h2;
   localparam logic [1:0] PM_AUTO = 2'h1;
   localparam logic [1:0] PM_INVALID = 2'h0;
   localparam logic [11:0] CODE_FLIP = 12'h800;
   localparam logic [11:0] CFG_RESET = 12'h030;
   localparam int CLK_NS = 4;
   localparam int SCLK_HALF_NS = 40;
   localparam int WAKE_NS = 1000;
   localparam logic [7:0] HALF_CYC = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] WAKE_CYC = 8'((WAKE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] REG_TX = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RX = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/acfg_if.sv
// Purpose: serial link between converter end and host end
// Assumes: dout line pulled high when nobody drives it
// Notes: sclk, cs_n and din are driven by the host only
`timescale 1ns/10ps
interface acfg_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;
   logic dout_line;
   assign dout_line = dout_oe ? dout : 1'b1;
   modport dev (input sclk, input cs_n, input din, output dout, output dout_oe);
   modport host (output sclk, output cs_n, output din, input dout_line);
endinterface

// file: design/acfg_dev.sv
// Purpose: converter end: config register, channel mux and power state
// Assumes: link pins asynchronous to clock_i; sclk slower than clock_i / 8
// Notes: the analog result arrives on sample_i for the converted channel
`timescale 1ns/10ps
module acfg_dev (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   acfg_if.dev link,
   input wire logic [11:0] sample_i,
   output logic [2:0] conv_channel_o,
   output logic powered_o,
   output logic [11:0] config_o,
   output logic [15:0] seq_table_o
);
   localparam int BIT_WRITE = acfg_pkg::BIT_WRITE;
   localparam int BIT_SEQ = acfg_pkg::BIT_SEQ;
   localparam int BIT_ADDR_HI = acfg_pkg::BIT_ADDR_HI;
   localparam int BIT_ADDR_LO = acfg_pkg::BIT_ADDR_LO;
   localparam int BIT_PM_HI = acfg_pkg::BIT_PM_HI;
   localparam int BIT_PM_LO = acfg_pkg::BIT_PM_LO;
   localparam int BIT_SHADOW = acfg_pkg::BIT_SHADOW;
   localparam int BIT_CODING = acfg_pkg::BIT_CODING;
   localparam logic [4:0] CNT_CFG_LAST = acfg_pkg::CNT_CFG_LAST;
   localparam logic [4:0] CNT_MUX = acfg_pkg::CNT_MUX;
   localparam logic [4:0] CNT_LAST = acfg_pkg::CNT_LAST;
   localparam logic [4:0] CNT_FULL = acfg_pkg::CNT_FULL;
   localparam logic [1:0] PM_NORMAL = acfg_pkg::PM_NORMAL;
   localparam logic [1:0] PM_SHUTDOWN = acfg_pkg::PM_SHUTDOWN;
   localparam logic [11:0] CODE_FLIP = acfg_pkg::CODE_FLIP;
   localparam logic [11:0] CFG_RESET = acfg_pkg::CFG_RESET;
   logic [2:0] s1_reg, s2_reg, s3_reg;
   logic [4:0] bit_cnt_reg;
   logic [15:0] in_sr_reg;
   logic [11:0] word_reg;
   logic [11:0] config_reg;
   logic [15:0] table_reg;
   logic [15:0] out_sr_reg;
   logic oe_reg;
   logic [2:0] mux_ch_reg;
   logic consec_reg;
   logic shadow_load_reg;
   logic powered_reg;

   // bit 2 cs_n, bit 1 sclk, bit 0 din
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_reg <= 3'h6;
         s2_reg <= 3'h6;
         s3_reg <= 3'h6;
      end else begin
         s1_reg <= {link.cs_n, link.sclk, link.din};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   wire cs_fall = s3_reg[2] & ~s2_reg[2];
   wire sclk_fall = s3_reg[1] & ~s2_reg[1] & ~s2_reg[2] & (bit_cnt_reg < CNT_FULL);
   wire din_s = s2_reg[0];
   wire [11:0] new_word = {in_sr_reg[10:0], din_s};
   wire use_new = word_reg[BIT_WRITE] & ~shadow_load_reg;
   wire [11:0] eff = use_new ? word_reg : config_reg;
   wire eff_seq = eff[BIT_SEQ];
   wire eff_shd = eff[BIT_SHADOW];
   wire [2:0] eff_addr = eff[BIT_ADDR_HI:BIT_ADDR_LO];
   wire [2:0] last_ch = config_reg[BIT_ADDR_HI:BIT_ADDR_LO];
   wire [1:0] pm_cfg = config_reg[BIT_PM_HI:BIT_PM_LO];
   wire [1:0] pm_word = word_reg[BIT_PM_HI:BIT_PM_LO];

   // channel field is plain unsigned binary, wraps to 0 past last
   function automatic logic [2:0] acfg_step(input logic [2:0] cur, input logic [2:0] last);
      acfg_step = (cur >= last) ? 3'h0 : 3'(cur + 3'h1);
   endfunction

   wire consec_next = eff_seq & (eff_shd | consec_reg);
   wire [2:0] ch_next = !consec_next ? eff_addr :
                        !consec_reg ? 3'h0 :
                        acfg_step(mux_ch_reg, eff_addr);
   wire [11:0] coded = powered_reg ?
                       (config_reg[BIT_CODING] ? sample_i : sample_i ^ CODE_FLIP) :
                       12'h000;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bit_cnt_reg <= 5'h00;
         in_sr_reg <= 16'h0000;
         word_reg <= 12'h000;
      end else if (cs_fall) begin
         bit_cnt_reg <= 5'h00;
         word_reg <= 12'h000;
      end else if (sclk_fall) begin
         bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
         in_sr_reg <= {in_sr_reg[14:0], din_s};
         if (bit_cnt_reg == CNT_CFG_LAST) begin
            word_reg <= new_word;
         end
      end
   end

   // config takes effect at the end of the transfer, for the next conversion
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         config_reg <= CFG_RESET;
         table_reg <= 16'h0000;
         shadow_load_reg <= 1'b0;
         powered_reg <= 1'b1;
      end else if (cs_fall) begin
         if (pm_cfg != PM_SHUTDOWN) begin
            powered_reg <= 1'b1;
         end
      end else if (sclk_fall && bit_cnt_reg == CNT_LAST) begin
         if (shadow_load_reg) begin
            table_reg <= {in_sr_reg[14:0], din_s};
            shadow_load_reg <= 1'b0;
         end else if (word_reg[BIT_WRITE]) begin
            config_reg <= word_reg;
            shadow_load_reg <= ~word_reg[BIT_SEQ] & word_reg[BIT_SHADOW];
            powered_reg <= (pm_word == PM_NORMAL);
         end
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mux_ch_reg <= 3'h0;
         consec_reg <= 1'b0;
      end else if (sclk_fall && bit_cnt_reg == CNT_MUX) begin
         mux_ch_reg <= ch_next;
         consec_reg <= consec_next;
      end
   end

   // result word: zero, channel, then twelve data bits
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         out_sr_reg <= 16'h0000;
         oe_reg <= 1'b0;
         conv_channel_o <= 3'h0;
      end else begin
         oe_reg <= ~s2_reg[2];
         if (cs_fall) begin
            out_sr_reg <= {1'b0, mux_ch_reg, coded};
            conv_channel_o <= mux_ch_reg;
         end else if (sclk_fall) begin
            out_sr_reg <= {out_sr_reg[14:0], 1'b0};
         end
      end
   end

   assign link.dout = out_sr_reg[15];
   assign link.dout_oe = oe_reg;
   assign powered_o = powered_reg;
   assign config_o = config_reg;
   assign seq_table_o = table_reg;
   // last_ch is read by nothing; the mode 1,0 continuation path steps against eff_addr
   wire unused_last = ^last_ch;
endmodule

// file: design/acfg_host.sv
// Purpose: host end: AXI4-Lite registers driving one 16-bit frame at a time
// Assumes: sclk made here by dividing clock_i, idles high
// Notes: TX write starts a frame; RX holds the word read during it
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module acfg_host (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   acfg_if.host link,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int BIT_WRITE = acfg_pkg::BIT_WRITE;
   localparam int BIT_PM_HI = acfg_pkg::BIT_PM_HI;
   localparam int BIT_PM_LO = acfg_pkg::BIT_PM_LO;
   localparam logic [4:0] CNT_FULL = acfg_pkg::CNT_FULL;
   localparam logic [1:0] PM_AUTO = acfg_pkg::PM_AUTO;
   localparam logic [1:0] PM_INVALID = acfg_pkg::PM_INVALID;
   localparam logic [7:0] HALF_CYC = acfg_pkg::HALF_CYC;
   localparam logic [7:0] WAKE_CYC = acfg_pkg::WAKE_CYC;
   localparam logic [3:0] REG_TX = acfg_pkg::REG_TX;
   localparam logic [3:0] REG_STATUS = acfg_pkg::REG_STATUS;
   localparam logic [3:0] REG_RX = acfg_pkg::REG_RX;
   localparam logic [1:0] RESP_OKAY = acfg_pkg::RESP_OKAY;
   localparam logic [1:0] RESP_SLVERR = acfg_pkg::RESP_SLVERR;
   typedef enum logic [2:0] {
      ACFG_IDLE = 3'h0, ACFG_LEAD = 3'h1, ACFG_LOW = 3'h3,
      ACFG_HIGH = 3'h2, ACFG_TRAIL = 3'h6, ACFG_GAP = 3'h4
   } acfg_state_t;

   acfg_state_t state_reg;
   logic [7:0] cnt_reg;
   logic [4:0] bits_reg;
   logic [15:0] tx_reg, rx_reg;
   logic sclk_reg, cs_n_reg, din_reg, auto_reg;
   logic d1_reg, d2_reg;
   logic [3:0] aw_reg;
   logic aw_have, w_have;
   logic [31:0] wd_reg;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         d1_reg <= 1'b1;
         d2_reg <= 1'b1;
      end else begin
         d1_reg <= link.dout_line;
         d2_reg <= d1_reg;
      end
   end

   wire busy = (state_reg != ACFG_IDLE);
   wire do_write = aw_have & w_have & ~s_axi_bvalid;
   wire [15:0] new_tx = wd_reg[15:0];
   wire bad_pm = new_tx[4 + BIT_WRITE] & (new_tx[4 + BIT_PM_HI:4 + BIT_PM_LO] == PM_INVALID);
   wire tx_hit = (aw_reg == REG_TX);
   wire tx_ok = tx_hit & ~busy & ~bad_pm & (&s_axi_wstrb[1:0]);
   wire half_done = (cnt_reg == 8'h01);
   wire [7:0] gap_len = auto_reg ? WAKE_CYC : 8'h01;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_reg <= 4'h0;
         wd_reg <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_reg <= s_axi_awaddr[3:0];
            aw_have <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_reg <= s_axi_wdata;
            w_have <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= tx_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   wire [3:0] ra = s_axi_araddr[3:0];
   wire [31:0] rd = (ra == REG_TX) ? {16'h0000, tx_reg} :
                    (ra == REG_STATUS) ? {31'h0, busy} :
                    {16'h0000, rx_reg};
   wire r_map = (ra == REG_TX) | (ra == REG_STATUS) | (ra == REG_RX);

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= r_map ? rd : 32'h0000_0000;
         s_axi_rresp <= r_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // frame engine: din changes on sclk rise, dout sampled at sclk fall
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= ACFG_IDLE;
         cnt_reg <= 8'h00;
         bits_reg <= 5'h00;
         tx_reg <= 16'h0000;
         rx_reg <= 16'h0000;
         sclk_reg <= 1'b1;
         cs_n_reg <= 1'b1;
         din_reg <= 1'b0;
         auto_reg <= 1'b0;
      end else begin
         cnt_reg <= half_done ? cnt_reg : 8'(cnt_reg - 8'h01);
         unique case (state_reg)
            ACFG_IDLE: begin
               if (do_write && tx_ok) begin
                  tx_reg <= new_tx;
                  din_reg <= new_tx[15];
                  cs_n_reg <= 1'b0;
                  bits_reg <= 5'h00;
                  cnt_reg <= HALF_CYC;
                  if (new_tx[4 + BIT_WRITE]) begin
                     auto_reg <= (new_tx[4 + BIT_PM_HI:4 + BIT_PM_LO] == PM_AUTO);
                  end
                  state_reg <= ACFG_LEAD;
               end
            end
            ACFG_LEAD, ACFG_HIGH: begin
               if (half_done) begin
                  sclk_reg <= 1'b0;
                  rx_reg <= {rx_reg[14:0], d2_reg};
                  bits_reg <= 5'(bits_reg + 5'h01);
                  cnt_reg <= HALF_CYC;
                  state_reg <= ACFG_LOW;
               end
            end
            ACFG_LOW: begin
               if (half_done) begin
                  sclk_reg <= 1'b1;
                  tx_reg <= {tx_reg[14:0], 1'b0};
                  din_reg <= tx_reg[14];
                  cnt_reg <= HALF_CYC;
                  state_reg <= (bits_reg == CNT_FULL) ? ACFG_TRAIL : ACFG_HIGH;
               end
            end
            ACFG_TRAIL: begin
               if (half_done) begin
                  cs_n_reg <= 1'b1;
                  cnt_reg <= gap_len;
                  state_reg <= ACFG_GAP;
               end
            end
            ACFG_GAP: begin
               if (half_done) begin
                  state_reg <= ACFG_IDLE;
               end
            end
            default: state_reg <= ACFG_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.din = din_reg;
endmodule

// file: sim/acfg_properties.sv
// Purpose: wire checks on the converter config link
// Assumes: both ends share clock_i and sys_rst_i
// Notes: instantiated beside the link interface
`timescale 1ns/10ps
module acfg_properties (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   logic [4:0] falls_reg;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         falls_reg <= 5'h00;
      end else if (cs_n) begin
         falls_reg <= 5'h00;
      end else if ($fell(sclk)) begin
         falls_reg <= falls_reg + 5'h01;
      end
   end
   frame_count_a: assert property ($rose(cs_n) |-> falls_reg == 5'h10)
      else $error("frame closed without sixteen clock falls");
   idle_clock_a: assert property (cs_n && $past(cs_n) |-> sclk)
      else $error("serial clock moved outside a frame");
   half_low_a: assert property ($fell(sclk) |-> !sclk [*8] ##3 $rose(sclk))
      else $error("serial clock low phase not ten cycles");
   din_hold_a: assert property ($fell(sclk) |=> $stable(din) [*8])
      else $error("data input changed while clock low");
   fall_framed_a: assert property ($fell(sclk) |-> !cs_n)
      else $error("clock fall outside a frame");
   select_high_a: assert property ($fell(cs_n) |-> sclk)
      else $error("frame opened with clock low");
   drive_on_a: assert property ($fell(cs_n) |-> ##[1:5] dout_oe)
      else $error("result line not driven after frame start");
   lead_zero_a: assert property ($fell(sclk) && falls_reg == 5'h00 |-> !dout)
      else $error("first result bit not zero");
   release_a: assert property ($rose(cs_n) |-> ##[1:5] !dout_oe)
      else $error("result line still driven after frame end");
   dout_steady_a: assert property ($fell(sclk) && !cs_n |-> $stable(dout))
      else $error("result bit moved at the sampling fall");
endmodule

// file: sim/acfg_bench.sv
// Purpose: bench for both ends of the converter config link
// Assumes: host end answers AXI4-Lite with registered outputs
// Notes: every frame is started through the TX register
`timescale 1ns/10ps
module acfg_bench;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] sample_i = 12'h000;
   logic [2:0] conv_channel_o;
   logic [2:0] nxt;
   logic powered_o;
   logic [11:0] config_o;
   logic [15:0] seq_table_o;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [15:0] rx;
   int bad_count = 0, comparisons = 0, cycles = 0;
   acfg_if link_i();
   acfg_dev acfg_dev_i(.clock_i, .sys_rst_i, .link(link_i.dev), .sample_i,
      .conv_channel_o, .powered_o, .config_o, .seq_table_o);
   acfg_host acfg_host_i(.clock_i, .sys_rst_i, .link(link_i.host), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   acfg_properties acfg_properties_i(.clock_i, .sys_rst_i, .sclk(link_i.sclk),
      .cs_n(link_i.cs_n), .din(link_i.din), .dout(link_i.dout), .dout_oe(link_i.dout_oe));
   initial begin
      forever #2 clock_i = ~clock_i;
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard: about four times the expected run
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // each bus task waits one edge first so no signal is driven twice in a step
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge clock_i);
      s_axi_awaddr <= {28'h0, a};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock_i);
      s_axi_araddr <= {28'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rx = s_axi_rdata[15:0];
      resp = s_axi_rresp;
   endtask
   task automatic send(input logic [15:0] d);
      wr(4'h0, d, acfg_pkg::RESP_OKAY);
      rd(4'h4);
      while (rx[0] !== 1'b0) rd(4'h4);
      rd(4'h8);
   endtask
   task automatic cfg(input logic [11:0] w);
      send({w, 4'h0});
   endtask
   task automatic t_chan();
      logic [11:0] w;
      logic [2:0] prev;
      prev = 3'h0;
      for (int c = 0; c < 8; c++) begin
         w = {2'b10, c[0], c[2:0], 2'b11, 1'b0, c[1], 2'b11};
         sample_i <= 12'h9c4 + 12'(c);
         cfg(w);
         // first frame still runs on reset coding, so the sign bit flips
         chk(rx, {1'b0, prev, (c == 0) ? 12'h1c4 : 12'h9c4 + 12'(c)});
         // the frame just run converts the channel picked by the word before
         chk(conv_channel_o, prev);
         chk(config_o & 12'hdfb, w & 12'hdfb);
         prev = c[2:0];
      end
   endtask
   task automatic t_hold();
      cfg(12'h080);
      chk(config_o & 12'hdfb, 12'h9f3);
      chk(conv_channel_o, 3'h7);
      chk(rx, 16'h79cb);
      wr(4'h0, 16'h8000, acfg_pkg::RESP_SLVERR);
      wr(4'hc, 16'h0000, acfg_pkg::RESP_SLVERR);
      rd(4'hc);
      chk(resp, acfg_pkg::RESP_SLVERR);
      chk(rx, 16'h0000);
      chk(config_o & 12'hdfb, 12'h9f3);
   endtask
   task automatic t_power();
      cfg(12'h813);
      chk(powered_o, 1'b0);
      repeat (acfg_pkg::WAKE_CYC) @(posedge clock_i);
      cfg(12'h823);
      chk(powered_o, 1'b0);
      cfg(12'h000);
      chk(powered_o, 1'b0);
      chk(rx, 16'h0000);
      cfg(12'h833);
      chk(powered_o, 1'b1);
   endtask
   task automatic t_seq();
      cfg(12'h838);
      send(16'h5ac3);
      chk(seq_table_o, 16'h5ac3);
      cfg(12'hcb9);
      cfg(12'h000);
      nxt = conv_channel_o;
      chk(nxt > 3'h2, 1'b0);
      repeat (3) begin
         nxt = (nxt == 3'h2) ? 3'h0 : nxt + 3'h1;
         cfg(12'h000);
         chk(conv_channel_o, nxt);
      end
      cfg(12'h8b1);
      chk(conv_channel_o, 3'h1);
      cfg(12'h000);
      chk(conv_channel_o, 3'h2);
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      chk(config_o, acfg_pkg::CFG_RESET);
      chk(powered_o, 1'b1);
      chk(seq_table_o, 16'h0000);
      t_chan();
      t_hold();
      t_power();
      t_seq();
      summarize();
   end
endmodule
